/* hdl/pup_top.sv */
// Operation
// [RULE1] A fixed delay after the supply passes the reset threshold every register is initialised and outputs take their polarity level.
// [RULE1] Here por_init clears only uout_ff.
// [RULE2] The board meets all input and feedback setup before its first clock edge after power-up reset.
// [RULE3] The board keeps the clock input free of transitions during the power-up reset delay; here pclk keeps running and the delay is counted on its edges.
// [RULE4] The reset detector offers small or large hysteresis, large being advised near 3.0V supplies.
// [RULE5] With the security fuse programmed, verify readback of the configuration is refused.
// [RULE6] The 16-bit user signature stays readable whatever the fuse state.
// [RULE7] Programming runs over a four-pin JTAG port, which an option can disable to free its pins for logic.
// [RULE8] An interrupted programming session locks the device and puts all input and I/O pins in high impedance.
// [RULE9] With the keeper option set by an earlier configuration, pins hold their last level during programming.
// [RULE10] Configuration memory starts out erased and ready for programming.
// [RULE11] The user signature gives two bytes of user-writable storage.
`timescale 1ns/100ps
`include "pup_defines.svh"
module pup_top
  import pup_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vcc_above_rst,
  input wire logic vcc_below_off,
  input wire logic isp_cable_n,
  input wire logic [3:0] jtag_pin_in,
  output logic [3:0] jtag_pin_out,
  output logic [3:0] jtag_pin_oe,
  input wire logic [7:0] user_pin_in,
  output logic [7:0] user_pin_out,
  output logic [7:0] user_pin_oe,
  output logic keeper_hold,
  output logic por_init,
  output logic isp_locked
);
  localparam logic [5:0] TD_CYC = 6'(`PUP_TD_CYC);

  logic [14:0] pins_s;
  logic vcc_ok;
  logic vcc_off;
  logic cable_gone;
  pup_por_e por_ff, nxt_por;
  pup_isp_e isp_ff, nxt_isp;
  logic [5:0] por_cnt_ff;
  logic [3:0] ctrl_ff;
  logic [15:0] sig_ff;
  pup_idx_t cidx_ff;
  pup_word_t cfg_ff [8];
  logic [23:0] uout_ff;
  logic keep_snap_ff;
  pup_word_t prdata_ff;
  logic err_ff;

  // Board pins cross into the bus clock domain
  pup_sync #(.WIDTH(15)) i_pup_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({user_pin_in, jtag_pin_in, isp_cable_n, vcc_below_off, vcc_above_rst}),
    .dout(pins_s)
  );
  assign vcc_ok = pins_s[0];
  assign vcc_off = pins_s[1];
  assign cable_gone = pins_s[2];

  // Bus phase decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction
  wire setup_ph = psel && !penable;
  wire acc_ph = psel && penable;
  wire wr_acc = acc_ph && pwrite;
  wire rd_setup = setup_ph && !pwrite;
  wire mapped = hit(paddr, `PUP_OFS_CTRL) || hit(paddr, `PUP_OFS_STAT) || hit(paddr, `PUP_OFS_SIG)
    || hit(paddr, `PUP_OFS_CIDX) || hit(paddr, `PUP_OFS_CDAT) || hit(paddr, `PUP_OFS_ISP)
    || hit(paddr, `PUP_OFS_UOUT) || hit(paddr, `PUP_OFS_PINS);
  wire fuse = ctrl_ff[`PUP_CTRL_FUSE];
  wire hyst_large = ctrl_ff[`PUP_CTRL_HYST];
  wire jtag_off = ctrl_ff[`PUP_CTRL_JOFF];
  wire isp_prog = (isp_ff == PUP_PROG);
  wire cdat_rd_refused = hit(paddr, `PUP_OFS_CDAT) && !pwrite && fuse; // RULE5
  wire cdat_wr_refused = hit(paddr, `PUP_OFS_CDAT) && pwrite && !isp_prog;
  wire por_run = (por_ff == PUP_RUN);

  // Supply loss depends on hysteresis: large waits for near shut-off
  wire vcc_lost = hyst_large ? vcc_off : !vcc_ok; // RULE4
  wire td_done = (por_cnt_ff == TD_CYC - 6'h01);
  always_comb begin
    nxt_por = por_ff;
    unique case (por_ff)
      PUP_OFF: if (vcc_ok && !vcc_off) nxt_por = PUP_WAIT;
      PUP_WAIT: if (!vcc_ok) nxt_por = PUP_OFF; else if (td_done) nxt_por = PUP_RUN;
      PUP_RUN: if (vcc_lost) nxt_por = PUP_OFF;
    endcase
  end
  assign por_init = (por_ff == PUP_WAIT) && vcc_ok && td_done; // RULE1

  // Reset delay counter, counted on pclk edges; board drivers hold still meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_ff <= PUP_OFF;
      por_cnt_ff <= 6'h00;
    end else begin
      por_ff <= nxt_por;
      por_cnt_ff <= (por_ff == PUP_WAIT) ? por_cnt_ff + 6'h01 : 6'h00; // RULE3
    end
  end

  // Programming session; a removed cable or lost supply is an interruption
  wire isp_cmd = wr_acc && hit(paddr, `PUP_OFS_ISP);
  wire isp_start = isp_cmd && pwdata[`PUP_ISP_START] && !jtag_off && por_run; // RULE7
  wire isp_finish = isp_cmd && pwdata[`PUP_ISP_FINISH];
  wire isp_abort = cable_gone || !por_run;
  always_comb begin
    nxt_isp = isp_ff;
    unique case (isp_ff)
      PUP_IDLE: if (isp_start) nxt_isp = PUP_PROG;
      PUP_PROG: if (isp_abort) nxt_isp = PUP_LOCK; else if (isp_finish) nxt_isp = PUP_IDLE; // RULE8
      PUP_LOCK: if (isp_start) nxt_isp = PUP_PROG;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isp_ff <= PUP_IDLE;
      keep_snap_ff <= 1'b0;
    end else begin
      isp_ff <= nxt_isp;
      if (isp_start) begin
        keep_snap_ff <= ctrl_ff[`PUP_CTRL_KEEP]; // RULE9
      end
    end
  end

  // Nonvolatile settings; writes can only set fuse, only presetn clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `PUP_CTRL_RST;
      sig_ff <= `PUP_SIG_RST;
      cidx_ff <= 3'h0;
    end else if (wr_acc) begin
      if (hit(paddr, `PUP_OFS_CTRL)) begin
        ctrl_ff <= {ctrl_ff[`PUP_CTRL_FUSE] | pwdata[`PUP_CTRL_FUSE], pwdata[2:0]}; // RULE5
      end
      if (hit(paddr, `PUP_OFS_SIG)) begin
        sig_ff <= pwdata[15:0]; // RULE11
      end
      if (hit(paddr, `PUP_OFS_CIDX)) begin
        cidx_ff <= pwdata[2:0];
      end
    end
  end

  // Configuration words start erased; written only inside a session
  genvar w;
  generate
    for (w = 0; w < 8; w++) begin : g_cfg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_ff[w] <= `PUP_CFG_ERASED; // RULE10
        end else if (wr_acc && hit(paddr, `PUP_OFS_CDAT) && isp_prog && cidx_ff == 3'(w)) begin
          cfg_ff[w] <= pwdata;
        end
      end
    end
  endgenerate

  // User output register cleared by the power-up reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uout_ff <= 24'h000000;
    end else if (por_init) begin
      uout_ff <= 24'h000000; // RULE1
    end else if (wr_acc && hit(paddr, `PUP_OFS_UOUT) && !isp_prog) begin
      uout_ff <= pwdata[23:0];
    end
  end

  // Read data is latched in setup so the access phase answers at once
  wire [31:0] stat_word = {27'h0, vcc_ok, fuse, isp_ff == PUP_LOCK, isp_prog, por_run};
  wire [31:0] rd_mux =
    hit(paddr, `PUP_OFS_CTRL) ? {28'h0, ctrl_ff} :
    hit(paddr, `PUP_OFS_STAT) ? stat_word :
    hit(paddr, `PUP_OFS_SIG) ? {16'h0, sig_ff} : // RULE6
    hit(paddr, `PUP_OFS_CIDX) ? {29'h0, cidx_ff} :
    (hit(paddr, `PUP_OFS_CDAT) && !fuse) ? cfg_ff[cidx_ff] : // RULE5
    hit(paddr, `PUP_OFS_UOUT) ? {8'h0, uout_ff} :
    hit(paddr, `PUP_OFS_PINS) ? {20'h0, pins_s[14:3]} : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      err_ff <= 1'b0;
    end else if (setup_ph) begin
      prdata_ff <= rd_setup ? rd_mux : 32'h00000000;
      err_ff <= !mapped || cdat_rd_refused || cdat_wr_refused;
    end
  end
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = acc_ph && err_ff;

  // Pin drive: polarity comes from configuration word zero
  wire pins_live = por_run && (isp_ff == PUP_IDLE);
  assign user_pin_out = uout_ff[7:0] ^ cfg_ff[0][7:0]; // RULE1
  assign user_pin_oe = pins_live ? uout_ff[15:8] : 8'h00; // RULE8
  assign keeper_hold = isp_prog && keep_snap_ff; // RULE9
  assign isp_locked = (isp_ff == PUP_LOCK);
  // Freed JTAG pins act as plain I/O; otherwise only the data-out pin drives
  assign jtag_pin_out = jtag_off ? uout_ff[19:16] : 4'h0;
  assign jtag_pin_oe = jtag_off ? (pins_live ? uout_ff[23:20] : 4'h0) : {isp_prog, 3'h0}; // RULE7

  chk_por_delay: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    por_init |-> $past(por_ff == PUP_WAIT, 1) ##1 (por_run && uout_ff == 24'h000000))
    else $error("power-up init did not clear outputs");
  chk_por_count: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    $rose(por_run) |-> $past(por_cnt_ff) == TD_CYC - 6'h01)
    else $error("reset delay length wrong");
  chk_hyst_small: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (por_run && !hyst_large && !vcc_ok) |=> por_ff == PUP_OFF)
    else $error("small hysteresis did not drop reset");
  chk_hyst_large: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (por_run && hyst_large && !vcc_off) |=> por_run)
    else $error("large hysteresis dropped early");
  chk_fuse_block: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (rd_setup && hit(paddr, `PUP_OFS_CDAT) && fuse) |=> (pslverr && prdata == 32'h00000000))
    else $error("verify readback not refused");
  chk_sig_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (rd_setup && hit(paddr, `PUP_OFS_SIG)) |=> (prdata == {16'h0, $past(sig_ff)} && !pslverr))
    else $error("signature not readable");
  chk_jtag_release: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (jtag_off && isp_ff == PUP_IDLE) |=> isp_ff == PUP_IDLE)
    else $error("session started on disabled port");
  chk_isp_lock: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (isp_prog && isp_abort) |=> (isp_locked && user_pin_oe == 8'h00)[*2])
    else $error("interrupted session did not lock");
  chk_keeper_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (isp_prog && keep_snap_ff) |-> (keeper_hold && user_pin_oe == 8'h00))
    else $error("keeper not holding");
endmodule

/* hdl/pup_defines.svh */
`ifndef PUP_DEFINES_SVH
`define PUP_DEFINES_SVH

// Clock and power-up reset delay
`define PUP_CLK_NS 25
`define PUP_TD_NS 1000
`define PUP_TD_CYC ((`PUP_TD_NS + `PUP_CLK_NS - 1) / `PUP_CLK_NS)

// Register byte offsets
`define PUP_OFS_CTRL 8'h00
`define PUP_OFS_STAT 8'h04
`define PUP_OFS_SIG 8'h08
`define PUP_OFS_CIDX 8'h0C
`define PUP_OFS_CDAT 8'h10
`define PUP_OFS_ISP 8'h14
`define PUP_OFS_UOUT 8'h18
`define PUP_OFS_PINS 8'h1C

// Control field positions
`define PUP_CTRL_HYST 0
`define PUP_CTRL_JOFF 1
`define PUP_CTRL_KEEP 2
`define PUP_CTRL_FUSE 3

// Status field positions
`define PUP_STAT_POR 0
`define PUP_STAT_ISP 1
`define PUP_STAT_LOCK 2
`define PUP_STAT_FUSE 3
`define PUP_STAT_VCC 4

// Programming command positions
`define PUP_ISP_START 0
`define PUP_ISP_FINISH 1

// Reset values
`define PUP_CFG_ERASED 32'hFFFFFFFF
`define PUP_CTRL_RST 4'h0
`define PUP_SIG_RST 16'hFFFF

`endif

/* hdl/pup_pkg.sv */
package pup_pkg;
  typedef enum logic [1:0] {PUP_OFF, PUP_WAIT, PUP_RUN} pup_por_e;
  typedef enum logic [1:0] {PUP_IDLE, PUP_PROG, PUP_LOCK} pup_isp_e;
  typedef logic [31:0] pup_word_t;
  typedef logic [2:0] pup_idx_t;
endpackage

/* hdl/pup_sync.sv */
`timescale 1ns/100ps
module pup_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;

  // Three stages; a bit moves only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_ff[i] <= 1'b0;
          s2_ff[i] <= 1'b0;
          s3_ff[i] <= 1'b0;
          q_ff[i] <= 1'b0;
        end else begin
          s1_ff[i] <= din[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (s2_ff[i] == s3_ff[i]) begin
            q_ff[i] <= s3_ff[i];
          end
        end
      end
    end
  endgenerate

  assign dout = q_ff;
endmodule

/* tb/pup_board.sv */
`timescale 1ns/100ps
module pup_board (
  input wire logic pclk,
  input wire logic supply_on,
  input wire logic supply_dead,
  input wire logic cable_pulled,
  input wire logic por_init,
  input wire logic [3:0] jtag_pin_out,
  input wire logic [3:0] jtag_pin_oe,
  input wire logic [7:0] user_pin_out,
  input wire logic [7:0] user_pin_oe,
  output logic vcc_above_rst,
  output logic vcc_below_off,
  output logic isp_cable_n,
  output logic [3:0] jtag_pin_in,
  output logic [7:0] user_pin_in
);
  logic [7:0] drive_ff;
  logic started_ff;
  // Supply monitor levels and programmer cable
  assign vcc_above_rst = supply_on;
  assign vcc_below_off = supply_dead;
  assign isp_cable_n = cable_pulled;
  // Board logic stays clock-quiet until the power-up delay has run out
  always_ff @(posedge pclk) begin
    started_ff <= supply_on && (started_ff || por_init);
  end
  // Board drivers stay still until then, so setup is met before they move
  always_ff @(posedge pclk) begin
    drive_ff <= started_ff ? ~drive_ff : 8'hA5;
  end
  // Wire levels from both parties; JTAG lines have pull-ups
  assign user_pin_in = (user_pin_oe & user_pin_out) | (~user_pin_oe & drive_ff);
  assign jtag_pin_in = (jtag_pin_oe & jtag_pin_out) | ~jtag_pin_oe;
endmodule

/* tb/pup_top_tb.sv */
`timescale 1ns/100ps
`include "pup_defines.svh"
module pup_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, user_pin_out, user_pin_oe, user_pin_in;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] jtag_pin_in, jtag_pin_out, jtag_pin_oe;
  logic vcc_above_rst, vcc_below_off, isp_cable_n, keeper_hold, por_init, isp_locked;
  logic supply_on, supply_dead, cable_pulled;
  int error_cnt = 0;
  int checked = 0;
  int n;
  pup_top i_pup_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vcc_above_rst(vcc_above_rst), .vcc_below_off(vcc_below_off), .isp_cable_n(isp_cable_n),
    .jtag_pin_in(jtag_pin_in), .jtag_pin_out(jtag_pin_out), .jtag_pin_oe(jtag_pin_oe),
    .user_pin_in(user_pin_in), .user_pin_out(user_pin_out), .user_pin_oe(user_pin_oe),
    .keeper_hold(keeper_hold), .por_init(por_init), .isp_locked(isp_locked));
  pup_board i_pup_board (.pclk(pclk), .supply_on(supply_on), .supply_dead(supply_dead),
    .cable_pulled(cable_pulled), .por_init(por_init), .jtag_pin_out(jtag_pin_out), .jtag_pin_oe(jtag_pin_oe),
    .user_pin_out(user_pin_out), .user_pin_oe(user_pin_oe), .vcc_above_rst(vcc_above_rst),
    .vcc_below_off(vcc_below_off), .isp_cable_n(isp_cable_n), .jtag_pin_in(jtag_pin_in),
    .user_pin_in(user_pin_in));
  // Free-running bus clock
  always #12.5 pclk = ~pclk;
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a slave that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Bounded wait for the power-up pulse, counting cycles
  task automatic wait_por();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (por_init !== 1'h1 && n < 200);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well above the expected run length
  initial begin
    #(25 * 4000);
    error_cnt++;
    wrap_up();
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    supply_on = 0; supply_dead = 0; cable_pulled = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, `PUP_OFS_SIG, 0); chk(rd, 32'h0000FFFF);
    apb(0, `PUP_OFS_CDAT, 0); chk(rd, `PUP_CFG_ERASED);
    apb(0, 8'h20, 0); chk({er, rd}, {1'h1, 32'h0});
    // Power-up: delay of at least the reset interval, then polarity level
    supply_on <= 1'h1;
    wait_por(); chk(n >= `PUP_TD_CYC && n < `PUP_TD_CYC + 10, 1'h1);
    @(posedge pclk); chk(user_pin_out, 8'hFF);
    apb(0, `PUP_OFS_STAT, 0); chk(rd[4:0], 5'h11);
    apb(1, `PUP_OFS_SIG, 32'h0000C3A5);
    apb(0, `PUP_OFS_SIG, 0); chk(rd, 32'h0000C3A5);
    // Session with keeper, then a config write and readback
    apb(1, `PUP_OFS_CTRL, 32'h4);
    apb(1, `PUP_OFS_ISP, 32'h1);
    repeat (2) @(posedge pclk);
    chk({keeper_hold, user_pin_oe, jtag_pin_oe}, {1'h1, 8'h00, 4'h8});
    apb(1, `PUP_OFS_CIDX, 32'h3);
    apb(1, `PUP_OFS_CDAT, 32'h00005A5A);
    apb(1, `PUP_OFS_ISP, 32'h2);
    apb(0, `PUP_OFS_CDAT, 0); chk({er, rd}, {1'h0, 32'h00005A5A});
    // Interrupted session locks and floats every pin
    apb(1, `PUP_OFS_ISP, 32'h1);
    cable_pulled <= 1'h1;
    repeat (8) @(posedge pclk);
    chk({isp_locked, user_pin_oe, jtag_pin_oe}, {1'h1, 12'h000});
    cable_pulled <= 1'h0;
    repeat (6) @(posedge pclk);
    apb(1, `PUP_OFS_ISP, 32'h1);
    repeat (2) @(posedge pclk);
    chk(isp_locked, 1'h0);
    apb(1, `PUP_OFS_ISP, 32'h2);
    // Port disabled: start command has no effect
    apb(1, `PUP_OFS_CTRL, 32'h2);
    apb(1, `PUP_OFS_ISP, 32'h1);
    apb(0, `PUP_OFS_STAT, 0); chk(rd[1], 1'h0);
    // Freed JTAG pins act as plain I/O and read back through the pin register
    apb(1, `PUP_OFS_UOUT, 32'h00F9FF0F);
    repeat (4) @(posedge pclk);
    chk({user_pin_out, user_pin_oe, jtag_pin_out, jtag_pin_oe}, {8'hF0, 8'hFF, 4'h9, 4'hF});
    apb(0, `PUP_OFS_PINS, 0); chk({er, rd}, {1'h0, 32'h00000F09});
    // Large hysteresis rides through a dip; small does not
    apb(1, `PUP_OFS_CTRL, 32'h1);
    supply_on <= 1'h0;
    repeat (8) @(posedge pclk);
    apb(0, `PUP_OFS_STAT, 0); chk(rd[0], 1'h1);
    supply_dead <= 1'h1;
    repeat (8) @(posedge pclk);
    apb(0, `PUP_OFS_STAT, 0); chk(rd[0], 1'h0);
    supply_dead <= 1'h0;
    supply_on <= 1'h1;
    apb(1, `PUP_OFS_CTRL, 32'h0);
    wait_por();
    supply_on <= 1'h0;
    repeat (8) @(posedge pclk);
    apb(0, `PUP_OFS_STAT, 0); chk(rd[0], 1'h0);
    // Fuse blocks readback, signature still readable
    apb(1, `PUP_OFS_CTRL, 32'h8);
    apb(0, `PUP_OFS_CDAT, 0); chk({er, rd}, {1'h1, 32'h0});
    apb(0, `PUP_OFS_SIG, 0); chk({er, rd}, {1'h0, 32'h0000C3A5});
    wrap_up();
  end
endmodule
